/* File: radio_regs_pkg.sv */
// Register map, field layout, reset values and timing of the radio control bank
package radio_regs_pkg;

  // Register offsets (register numbers as seen on the SPI address byte)
  localparam logic [6:0] OFS_SYNTH_LOCK    = 7'h03;
  localparam logic [6:0] OFS_SIGNAL_LEVEL  = 7'h06;
  localparam logic [6:0] OFS_CHANNEL_RUN   = 7'h07;
  localparam logic [6:0] OFS_POWER_AMP     = 7'h09;
  localparam logic [6:0] OFS_OSCILLATOR    = 7'h0A;
  localparam logic [6:0] OFS_TEST_MODE     = 7'h0B;
  localparam logic [6:0] OFS_CALIBRATION   = 7'h17;
  localparam logic [6:0] OFS_SLEEP_REG     = 7'h1B;
  localparam logic [6:0] OFS_REVISION      = 7'h1D;
  localparam logic [6:0] OFS_IDENT_LOW     = 7'h1E;
  localparam logic [6:0] OFS_IDENT_HIGH    = 7'h1F;
  localparam logic [6:0] OFS_PACKET_FORMAT = 7'h20;
  localparam logic [6:0] OFS_FRAMER_CTRL   = 7'h29;

  // Writable bit masks; everything else is reserved and reads zero
  localparam logic [15:0] MASK_CHANNEL_RUN   = 16'h01FF;
  localparam logic [15:0] MASK_POWER_AMP     = 16'h0780;
  localparam logic [15:0] MASK_OSCILLATOR    = 16'h0001;
  localparam logic [15:0] MASK_TEST_MODE     = 16'h8200;
  localparam logic [15:0] MASK_CALIBRATION   = 16'h0004;
  localparam logic [15:0] MASK_SLEEP_REG     = 16'hF800;
  localparam logic [15:0] MASK_PACKET_FORMAT = 16'hFFC0;
  localparam logic [15:0] MASK_FRAMER_CTRL   = 16'h7000;

  // Reset values of the stored bits
  localparam logic [15:0] RST_CHANNEL_RUN   = 16'h0030;
  localparam logic [15:0] RST_POWER_AMP     = 16'h0000;
  localparam logic [15:0] RST_OSCILLATOR    = 16'h0001;
  localparam logic [15:0] RST_TEST_MODE     = 16'h0000;
  localparam logic [15:0] RST_CALIBRATION   = 16'h0004;
  localparam logic [15:0] RST_SLEEP_REG     = 16'h9000;
  localparam logic [15:0] RST_PACKET_FORMAT = 16'h5800;
  localparam logic [15:0] RST_FRAMER_CTRL   = 16'h3000;

  // Field positions
  localparam int LOCK_BIT        = 12;
  localparam int LEVEL_LSB       = 10;
  localparam int TX_GO_BIT       = 8;
  localparam int RX_GO_BIT       = 7;
  localparam int CHAN_MSB        = 6;
  localparam int PA_MSB          = 10;
  localparam int PA_LSB          = 7;
  localparam int XTAL_BIT        = 0;
  localparam int CARRIER_BIT     = 15;
  localparam int LEVEL_OFF_BIT   = 9;
  localparam int AUTOCAL_BIT     = 2;
  localparam int SLEEP_LSB       = 11;
  localparam int ANALOG_REV_LSB  = 4;
  localparam int PREAMBLE_LSB    = 13;
  localparam int SYNC_LSB        = 11;
  localparam int TRAILER_LSB     = 8;
  localparam int DATATYPE_LSB    = 6;
  localparam int WHITEN_BIT      = 14;
  localparam int LENGTH_BYTE_BIT = 13;
  localparam int AUTO_STOP_BIT   = 12;

  // SPI frame: one command byte (read flag + address) then one 16-bit word
  localparam int CMD_BITS   = 8;
  localparam int FRAME_BITS = 24;
  localparam int READ_FLAG  = 7;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS   = 1000;
  localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int CAL_TIME_NS   = 150000;
  localparam int CAL_CYCLES    = CAL_TIME_NS / CLK_PERIOD_NS;

  // Frequency offset applied to the synthesiser
  typedef enum logic [1:0] {TONE_CENTRE, TONE_MARK, TONE_SPACE} tone_t;

  typedef enum logic [1:0] {RUN_IDLE, RUN_CAL, RUN_TX, RUN_RX} run_state_t;

  typedef struct packed {
    logic [6:0] channel_select;
    logic [3:0] power_amp_level;
    logic       crystal_amp_enable;
    logic       signal_level_off;
    logic [4:0] sleep_regulator_current;
  } rf_setup_t;

  typedef struct packed {
    logic [2:0] preamble_size;
    logic [1:0] sync_pattern_size;
    logic [2:0] trailer_size;
    logic [1:0] data_type;
    logic       whitening_enable;
    logic       length_byte_enable;
    logic       auto_tx_stop_select;
  } packet_format_t;

endpackage : radio_regs_pkg

/* File: radio_control_register_bank.sv */
// Radio control register bank with SPI slave, run sequencer and test-mode data path
//
// Contract
// - Carrier-only with transmit started keeps transmitter on, unmodulated; auto-stop, when selected, still ends the burst.
// - Carrier-only transmit sits midway between mark and space frequencies.
// - Random-data test mode cycles FIFO contents through the whitening scrambler, endlessly unless auto-stop is selected.
// - Clearing both go bits returns device to idle; neither transmit nor receive runs.
// - Every register is reached over SPI and is 16 bits wide.
// - Lock status bit 12 reads synthesiser phase lock, 1 when locked.
// - Signal-level bits 15:10 return the 6-bit raw signal strength.
// - Transmit-go bit 8 launches transmit; receive-go bit 7 launches receive.
// - Channel field bits 6:0 selects channel 2402+n MHz, 0 to 78.
// - Power register bits 10:7 set the power-amplifier level.
// - Oscillator bit 0 enables the crystal amplifier when one.
// - Test-mode bit 15 suppresses modulation, sending carrier only.
// - Test-mode bit 9 switches signal-strength measurement off.
// - Calibration bit 2 calibrates the oscillator before every transmit or receive.
// - Sleep register bits 15:11 select sleep regulator current.
// - Revision register gives analog and digital revisions; two fixed identity registers.
// - Preamble field 15:13 gives 1, 2 or 3 bytes, default 010b.
// - Sync field 12:11 picks 16 to 64 sync bits, default 11b.
// - Trailer field 10:8 gives 4 to 10 bits, default 000b.
// - Data type field 7:6 selects NRZ coding at 00b, its default.
// - Whitening scrambles transmit data and descrambles receive data.
`timescale 1ns/1ps

module radio_control_register_bank #(
  parameter int         CAL_CYCLES_P = radio_regs_pkg::CAL_CYCLES,
  parameter int         BIT_CYCLES_P = radio_regs_pkg::BIT_CYCLES,
  parameter int         FIFO_AW      = 6,
  parameter logic [6:0] WHITEN_SEED  = 7'h7F,
  parameter logic [3:0] ANALOG_REV   = 4'h1,   // Arbitrary value
  parameter logic [2:0] DIGITAL_REV  = 3'h1,   // Arbitrary value
  parameter logic [15:0] IDENT_LOW   = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] IDENT_HIGH  = 16'hA5C3  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // SPI slave pins
  input  wire logic                           spi_ss_n,
  input  wire logic                           spi_sck,
  input  wire logic                           spi_mosi,
  output logic                                spi_miso,
  output logic                                spi_miso_oe,
  // Analog status inputs
  input  wire logic                           synth_locked_flag,
  input  wire logic [5:0]                     signal_level_raw,
  // Packet FIFO read side
  output logic [FIFO_AW-1:0]                  fifo_rd_addr,
  input  wire logic [7:0]                     fifo_rd_data,
  input  wire logic [FIFO_AW-1:0]             fifo_wr_ptr,
  // Receive bit stream
  input  wire logic                           rx_line_bit,
  input  wire logic                           rx_line_strobe,
  output logic                                rx_data_bit,
  output logic                                rx_data_strobe,
  // Radio controls
  output radio_regs_pkg::rf_setup_t           rf_setup,
  output radio_regs_pkg::packet_format_t      packet_format,
  output radio_regs_pkg::run_state_t          run_state,
  output logic                                osc_cal_active,
  output logic                                tx_on,
  output logic                                rx_on,
  output radio_regs_pkg::tone_t               tx_tone
);
  import radio_regs_pkg::*;

  localparam int CAL_W = $clog2(CAL_CYCLES_P + 1);
  localparam int BIT_W = $clog2(BIT_CYCLES_P + 1);

  // Stored registers, reserved bits held at zero
  logic [15:0] channel_run_reg;
  logic [15:0] power_amp_reg;
  logic [15:0] oscillator_reg;
  logic [15:0] test_mode_reg;
  logic [15:0] calibration_reg;
  logic [15:0] sleep_reg;
  logic [15:0] packet_format_reg;
  logic [15:0] framer_ctrl_reg;
  logic [5:0]  level_hold_reg;

  // SPI engine state
  logic                sck_prev_reg;
  logic [4:0]          bit_cnt_reg;
  logic [7:0]          cmd_reg;
  logic [15:0]         shift_in_reg;
  logic [15:0]         shift_out_reg;
  logic                sck_rise;
  logic                sck_fall;
  logic                wr_commit;
  logic [15:0]         wr_data;
  logic [15:0]         rd_data;

  // Sequencer and data path state
  run_state_t          state_reg;
  run_state_t          state_next;
  logic [CAL_W-1:0]    cal_cnt_reg;
  logic [BIT_W-1:0]    bit_timer_reg;
  logic [2:0]          bit_idx_reg;
  logic [FIFO_AW-1:0]  rd_addr_reg;
  logic [6:0]          lfsr_reg;
  logic                tx_stop;
  logic                tx_go;
  logic                rx_go;
  logic                bit_tick;
  logic                raw_bit;
  logic                whiten_bit;
  logic [FIFO_AW-1:0]  rd_addr_next;

  // Edges of the sampled serial clock; mode 0 framing
  assign sck_rise  = !spi_ss_n && spi_sck && !sck_prev_reg;
  assign sck_fall  = !spi_ss_n && !spi_sck && sck_prev_reg;
  assign wr_data   = {shift_in_reg[14:0], spi_mosi};
  assign wr_commit = sck_rise && (bit_cnt_reg == 5'(FRAME_BITS - 1)) && !cmd_reg[READ_FLAG];

  // Frame position and shift-in; deselect aborts a partial frame
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_reg <= 1'b0;
      bit_cnt_reg  <= 5'h00;
      cmd_reg      <= 8'h00;
      shift_in_reg <= 16'h0000;
    end else begin
      sck_prev_reg <= spi_sck;
      if (spi_ss_n) begin
        bit_cnt_reg <= 5'h00;
      end else if (sck_rise) begin
        shift_in_reg <= wr_data;
        if (bit_cnt_reg == 5'(CMD_BITS - 1)) begin
          cmd_reg <= wr_data[7:0];
        end
        if (bit_cnt_reg != 5'(FRAME_BITS - 1)) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end else begin
          bit_cnt_reg <= 5'h00; // Back-to-back frames under one select
        end
      end
    end
  end

  // Read word loaded after the command byte, shifted out MSB first on falling edges
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_out_reg <= 16'h0000;
    end else if (sck_rise && bit_cnt_reg == 5'(CMD_BITS - 1)) begin
      shift_out_reg <= rd_data;
    end else if (sck_fall && bit_cnt_reg > 5'(CMD_BITS)) begin
      shift_out_reg <= {shift_out_reg[14:0], 1'b0};
    end
  end

  assign spi_miso    = shift_out_reg[15];
  assign spi_miso_oe = !spi_ss_n; // Releases the line so other slaves can share it

  // Read multiplexer keyed by the address just received
  always_comb begin
    rd_data = 16'h0000;
    case (wr_data[6:0])
      OFS_SYNTH_LOCK:    rd_data[LOCK_BIT] = synth_locked_flag;
      OFS_SIGNAL_LEVEL:  rd_data[LEVEL_LSB +: 6] = level_hold_reg;
      OFS_CHANNEL_RUN:   rd_data = channel_run_reg;
      OFS_POWER_AMP:     rd_data = power_amp_reg;
      OFS_OSCILLATOR:    rd_data = oscillator_reg;
      OFS_TEST_MODE:     rd_data = test_mode_reg;
      OFS_CALIBRATION:   rd_data = calibration_reg;
      OFS_SLEEP_REG:     rd_data = sleep_reg;
      OFS_REVISION:      rd_data = {8'h00, ANALOG_REV, 1'b0, DIGITAL_REV};
      OFS_IDENT_LOW:     rd_data = IDENT_LOW;
      OFS_IDENT_HIGH:    rd_data = IDENT_HIGH;
      OFS_PACKET_FORMAT: rd_data = packet_format_reg;
      OFS_FRAMER_CTRL:   rd_data = framer_ctrl_reg;
      default:           rd_data = 16'h0000;
    endcase
  end

  // Configuration registers; only the documented bits are stored
  always_ff @(posedge clk) begin
    if (rst) begin
      power_amp_reg     <= RST_POWER_AMP;
      oscillator_reg    <= RST_OSCILLATOR;
      test_mode_reg     <= RST_TEST_MODE;
      calibration_reg   <= RST_CALIBRATION;
      sleep_reg         <= RST_SLEEP_REG;
      packet_format_reg <= RST_PACKET_FORMAT;
      framer_ctrl_reg   <= RST_FRAMER_CTRL;
    end else if (wr_commit) begin
      case (cmd_reg[6:0])
        OFS_POWER_AMP:     power_amp_reg     <= wr_data & MASK_POWER_AMP;
        OFS_OSCILLATOR:    oscillator_reg    <= wr_data & MASK_OSCILLATOR;
        OFS_TEST_MODE:     test_mode_reg     <= wr_data & MASK_TEST_MODE;
        OFS_CALIBRATION:   calibration_reg   <= wr_data & MASK_CALIBRATION;
        OFS_SLEEP_REG:     sleep_reg         <= wr_data & MASK_SLEEP_REG;
        OFS_PACKET_FORMAT: packet_format_reg <= wr_data & MASK_PACKET_FORMAT;
        OFS_FRAMER_CTRL:   framer_ctrl_reg   <= wr_data & MASK_FRAMER_CTRL;
        default:           ;
      endcase
    end
  end

  // Channel and run bits; the sequencer drops transmit-go when auto-stop reaches the write pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_run_reg <= RST_CHANNEL_RUN;
    end else if (wr_commit && cmd_reg[6:0] == OFS_CHANNEL_RUN) begin
      channel_run_reg <= wr_data & MASK_CHANNEL_RUN;
    end else if (tx_stop) begin
      channel_run_reg[TX_GO_BIT] <= 1'b0;
    end
  end

  // Signal strength frozen while measurement is switched off
  always_ff @(posedge clk) begin
    if (rst) begin
      level_hold_reg <= 6'h00;
    end else if (!test_mode_reg[LEVEL_OFF_BIT]) begin
      level_hold_reg <= signal_level_raw;
    end
  end

  // Decoded fields to the analog front end and framer
  always_comb begin
    rf_setup.channel_select          = channel_run_reg[CHAN_MSB:0];
    rf_setup.power_amp_level         = power_amp_reg[PA_MSB:PA_LSB];
    rf_setup.crystal_amp_enable      = oscillator_reg[XTAL_BIT];
    rf_setup.signal_level_off        = test_mode_reg[LEVEL_OFF_BIT];
    rf_setup.sleep_regulator_current = sleep_reg[SLEEP_LSB +: 5];
    packet_format.preamble_size       = packet_format_reg[PREAMBLE_LSB +: 3];
    packet_format.sync_pattern_size   = packet_format_reg[SYNC_LSB +: 2];
    packet_format.trailer_size        = packet_format_reg[TRAILER_LSB +: 3];
    packet_format.data_type           = packet_format_reg[DATATYPE_LSB +: 2];
    packet_format.whitening_enable    = framer_ctrl_reg[WHITEN_BIT];
    packet_format.length_byte_enable  = framer_ctrl_reg[LENGTH_BYTE_BIT];
    packet_format.auto_tx_stop_select = framer_ctrl_reg[AUTO_STOP_BIT];
  end

  // Transmit wins if software breaks the exclusive-go convention
  assign tx_go = channel_run_reg[TX_GO_BIT];
  assign rx_go = channel_run_reg[RX_GO_BIT] && !tx_go;

  // Run sequencer: optional calibration, then transmit or receive until go drops
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RUN_IDLE: begin
        if (tx_go || rx_go) begin
          if (calibration_reg[AUTOCAL_BIT]) begin
            state_next = RUN_CAL;
          end else begin
            state_next = tx_go ? RUN_TX : RUN_RX;
          end
        end
      end
      RUN_CAL: begin
        if (!tx_go && !rx_go) begin
          state_next = RUN_IDLE;
        end else if (cal_cnt_reg == CAL_W'(CAL_CYCLES_P - 1)) begin
          state_next = tx_go ? RUN_TX : RUN_RX;
        end
      end
      RUN_TX: begin
        if (!tx_go || tx_stop) begin
          state_next = RUN_IDLE;
        end
      end
      RUN_RX: begin
        if (!rx_go) begin
          state_next = RUN_IDLE;
        end
      end
      default: state_next = RUN_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= RUN_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Calibration interval counter
  always_ff @(posedge clk) begin
    if (rst || state_reg != RUN_CAL) begin
      cal_cnt_reg <= '0;
    end else begin
      cal_cnt_reg <= cal_cnt_reg + CAL_W'(1);
    end
  end

  assign run_state      = state_reg;
  assign osc_cal_active = (state_reg == RUN_CAL);
  assign tx_on          = (state_reg == RUN_TX);
  assign rx_on          = (state_reg == RUN_RX);

  // Bit clock of the transmit serialiser
  assign bit_tick = (state_reg == RUN_TX) && (bit_timer_reg == BIT_W'(BIT_CYCLES_P - 1));

  always_ff @(posedge clk) begin
    if (rst || state_reg != RUN_TX || bit_tick) begin
      bit_timer_reg <= '0;
    end else begin
      bit_timer_reg <= bit_timer_reg + BIT_W'(1);
    end
  end

  // FIFO walk: wraps forever unless auto-stop ends the burst at the write pointer
  assign rd_addr_next = rd_addr_reg + FIFO_AW'(1);
  assign tx_stop      = bit_tick && (bit_idx_reg == 3'h7) &&
                        packet_format.auto_tx_stop_select && (rd_addr_next == fifo_wr_ptr);

  always_ff @(posedge clk) begin
    if (rst || state_reg == RUN_IDLE) begin
      bit_idx_reg <= 3'h0;
      rd_addr_reg <= '0;
    end else if (bit_tick) begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
      if (bit_idx_reg == 3'h7) begin
        rd_addr_reg <= rd_addr_next;
      end
    end
  end

  assign fifo_rd_addr = rd_addr_reg;

  // Shared whitening sequence, restarted at each run so both ends align
  always_ff @(posedge clk) begin
    if (rst || state_reg == RUN_IDLE) begin
      lfsr_reg <= WHITEN_SEED;
    end else if (bit_tick || (state_reg == RUN_RX && rx_line_strobe)) begin
      lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[3]};
    end
  end

  // Scrambling disabled leaves data untouched
  assign whiten_bit = packet_format.whitening_enable & lfsr_reg[6];
  assign raw_bit    = fifo_rd_data[bit_idx_reg] ^ whiten_bit;

  // Frequency offset: centre for carrier-only, otherwise mark or space per bit
  always_ff @(posedge clk) begin
    if (rst || state_reg != RUN_TX) begin
      tx_tone <= TONE_CENTRE;
    end else if (test_mode_reg[CARRIER_BIT]) begin
      tx_tone <= TONE_CENTRE;
    end else begin
      tx_tone <= raw_bit ? TONE_MARK : TONE_SPACE;
    end
  end

  // Receive descrambler; one bit out per strobe while receiving
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_bit    <= 1'b0;
      rx_data_strobe <= 1'b0;
    end else begin
      rx_data_strobe <= (state_reg == RUN_RX) && rx_line_strobe;
      if (state_reg == RUN_RX && rx_line_strobe) begin
        rx_data_bit <= rx_line_bit ^ whiten_bit;
      end
    end
  end

endmodule : radio_control_register_bank

/* File: radio_bank_checker.sv */
// Port-level assertions for the radio control register bank
`timescale 1ns/1ps
module radio_bank_checker #(
  parameter int CAL_CYCLES_P = 20
) (
  // Clock and reset
  input wire logic                           clk,
  input wire logic                           rst,
  // Host pins
  input wire logic                           spi_ss_n,
  input wire logic                           spi_miso_oe,
  // Receive stream
  input wire logic                           rx_line_bit,
  input wire logic                           rx_line_strobe,
  input wire logic                           rx_data_bit,
  input wire logic                           rx_data_strobe,
  // Radio controls
  input wire radio_regs_pkg::rf_setup_t      rf_setup,
  input wire radio_regs_pkg::packet_format_t packet_format,
  input wire radio_regs_pkg::run_state_t     run_state,
  input wire logic                           osc_cal_active,
  input wire logic                           tx_on,
  input wire logic                           rx_on,
  input wire radio_regs_pkg::tone_t          tx_tone
);
  import radio_regs_pkg::*;
  logic [15:0] cal_cnt_reg;
  // Counts calibration cycles; the dwell is too long for a repetition
  always_ff @(posedge clk) begin
    if (rst || !osc_cal_active) cal_cnt_reg <= 16'h0000;
    else cal_cnt_reg <= cal_cnt_reg + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rx_bit; rx_on && rx_line_strobe; endsequence
  sequence s_cal_end; $fell(osc_cal_active) ##0 (tx_on || rx_on); endsequence
  AST_TXRX_EXCL: assert property (!(tx_on && rx_on))
    else $error("transmit and receive both on");
  AST_RUN_DECODE: assert property ((tx_on == (run_state == RUN_TX))
    && (rx_on == (run_state == RUN_RX)) && (osc_cal_active == (run_state == RUN_CAL)))
    else $error("run levels disagree with state");
  AST_CAL_DWELL: assert property (s_cal_end |-> cal_cnt_reg == CAL_CYCLES_P)
    else $error("calibration dwell wrong");
  AST_RX_ECHO: assert property (s_rx_bit |=> rx_data_strobe)
    else $error("received bit not passed on");
  AST_RX_PLAIN: assert property (s_rx_bit ##0 !packet_format.whitening_enable
    |=> rx_data_bit == $past(rx_line_bit)) else $error("plain bit altered");
  AST_NO_STRAY: assert property (rx_data_strobe |-> $past(rx_on) && $past(rx_line_strobe))
    else $error("bit strobe outside receive");
  AST_IDLE_TONE: assert property (!tx_on && !$past(tx_on) |-> tx_tone == TONE_CENTRE)
    else $error("tone offset while transmitter off");
  AST_MISO_OE: assert property (spi_miso_oe == !spi_ss_n)
    else $error("data out enable wrong");
  AST_SETUP_HOLD: assert property (spi_ss_n && $past(spi_ss_n) && $past(spi_ss_n, 2)
    && !$past(rst) |-> $stable(rf_setup) && $stable(packet_format))
    else $error("settings changed without host");
  AST_START_BY_HOST: assert property ($past(run_state) == RUN_IDLE
    && run_state != RUN_IDLE |-> !$past(spi_ss_n, 2)) else $error("run started unbidden");
endmodule : radio_bank_checker

/* File: spi_host_model.sv */
// Host microcontroller model: SPI master in mode 0
`timescale 1ns/1ps
module spi_host_model (
  // Pacing clock
  input  wire logic clk,
  // SPI pins
  output logic      spi_ss_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  import radio_regs_pkg::*;
  localparam int HALF = 4; // Clocks per sck phase, above the one the slave needs
  initial begin
    spi_ss_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  // Steps n clock edges, then moves clear of the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One frame: command byte, then a 16-bit word, MSB first
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [23:0] sh;
    sh = {rd, adr, wd};
    rdat = 16'h0000;
    if (!rd && adr == OFS_CHANNEL_RUN) sh[7] = sh[7] & ~sh[8];
    tick(1);
    spi_ss_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      spi_mosi = sh[23-i];
      tick(HALF);
      spi_sck = 1'b1;
      if (i >= 8) rdat = {rdat[14:0], spi_miso};
      tick(HALF);
      spi_sck = 1'b0;
    end
    tick(HALF);
    spi_ss_n = 1'b1;
    spi_mosi = ~spi_mosi; // Released line must not keep its last value
  endtask : xfer
endmodule : spi_host_model

/* File: radio_control_register_bank_tb.sv */
// Self-checking bench for the radio control register bank
`timescale 1ns/1ps
module radio_control_register_bank_tb;
  import radio_regs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spi_ss_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic synth_locked_flag = 1'b0;
  logic [5:0] signal_level_raw = 6'h00;
  logic rx_line_bit = 1'b0;
  logic rx_line_strobe = 1'b0;
  logic rx_data_bit, rx_data_strobe, osc_cal_active, tx_on, rx_on;
  logic [5:0] fifo_rd_addr;
  logic [7:0] fifo_rd_data = 8'h00;
  logic [5:0] fifo_wr_ptr = 6'h00;
  rf_setup_t rf_setup;
  packet_format_t packet_format;
  run_state_t run_state;
  tone_t tx_tone;
  logic [15:0] rd;
  logic [3:0] tones;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Address, reset value, value after writing all ones
  localparam logic [38:0] TBL [12] = '{{7'h03, 16'h0000, 16'h0000},
    {7'h06, 16'h0000, 16'h0000}, {7'h09, 16'h0000, 16'h0780}, {7'h0A, 16'h0001, 16'h0001},
    {7'h0B, 16'h0000, 16'h8200}, {7'h17, 16'h0004, 16'h0004}, {7'h1B, 16'h9000, 16'hF800},
    {7'h1D, 16'h0011, 16'h0011}, {7'h1E, 16'h1357, 16'h1357}, {7'h1F, 16'h2468, 16'h2468},
    {7'h20, 16'h5800, 16'hFFC0}, {7'h05, 16'h0000, 16'h0000}};
  localparam logic [7:0] PAT = 8'hB4;

  always #5 clk = ~clk;

  // FIFO bytes stay zero; the write pointer moves for the auto-stop test
  radio_control_register_bank #(.CAL_CYCLES_P(20), .BIT_CYCLES_P(4),
    .IDENT_LOW(16'h1357), .IDENT_HIGH(16'h2468) // Arbitrary values
  ) u_radio_control_register_bank (.clk(clk), .rst(rst), .spi_ss_n(spi_ss_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .synth_locked_flag(synth_locked_flag), .signal_level_raw(signal_level_raw),
    .fifo_rd_addr(fifo_rd_addr), .fifo_rd_data(fifo_rd_data), .fifo_wr_ptr(fifo_wr_ptr),
    .rx_line_bit(rx_line_bit), .rx_line_strobe(rx_line_strobe), .rx_data_bit(rx_data_bit),
    .rx_data_strobe(rx_data_strobe), .rf_setup(rf_setup), .packet_format(packet_format),
    .run_state(run_state), .osc_cal_active(osc_cal_active), .tx_on(tx_on), .rx_on(rx_on),
    .tx_tone(tx_tone));

  spi_host_model u_spi_host_model (.clk(clk), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  task automatic tk();
    @(posedge clk);
    #1;
  endtask : tk
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_spi_host_model.xfer(1'b0, a, d, rd);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    u_spi_host_model.xfer(1'b1, a, 16'h0000, rd);
    check(rd, exp);
  endtask : rdchk
  // Bounded wait for a run to begin
  task automatic wait_run();
    for (int i = 0; i < 64 && !(tx_on || rx_on); i++) tk();
  endtask : wait_run
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // A hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 12; i++) rdchk(TBL[i][38:32], TBL[i][31:16]);
    rdchk(7'h07, 16'h0030);
    for (int i = 0; i < 12; i++) wr(TBL[i][38:32], 16'hFFFF);
    for (int i = 0; i < 12; i++) rdchk(TBL[i][38:32], TBL[i][15:0]);
    check({5'h00, rf_setup[10:0]}, 16'h07FF);
    check({6'h00, packet_format[12:3]}, 16'h03FF);
    wr(7'h07, 16'h004E);
    rdchk(7'h07, 16'h004E);
    check({9'h000, rf_setup.channel_select}, 16'h004E);
    wr(7'h0B, 16'h0000);
    synth_locked_flag = 1'b1;
    signal_level_raw = 6'h2B;
    rdchk(7'h03, 16'h1000);
    rdchk(7'h06, 16'hAC00);
    wr(7'h0B, 16'h0200);
    signal_level_raw = 6'h11;
    rdchk(7'h06, 16'hAC00);
    // Carrier only, with calibration ahead of the run
    wr(7'h0B, 16'h8000);
    wr(7'h29, 16'hC000);
    wr(7'h07, 16'h014E);
    check(16'(run_state), 16'(RUN_CAL));
    wait_run();
    repeat (40) begin
      tk();
      check({14'h0000, tx_on, tx_tone == TONE_CENTRE}, 16'h0003);
    end
    wr(7'h07, 16'h004E);
    check({12'h000, run_state, tx_on, rx_on}, 16'h0000);
    // Random data from an all-zero FIFO, calibration off
    wr(7'h0B, 16'h0000);
    wr(7'h17, 16'h0000);
    wr(7'h07, 16'h0100);
    check({15'h0000, tx_on}, 16'h0001);
    tones = 4'h0;
    repeat (160) begin
      tk();
      tones[tx_tone] = 1'b1;
    end
    check({12'h000, tones}, 16'h0006);
    // Auto stop ends the burst after the byte just before the write pointer
    wr(7'h07, 16'h0000);
    fifo_wr_ptr = 6'h01;
    wr(7'h29, 16'h1000);
    wr(7'h07, 16'h0100);
    repeat (40) tk();
    check({15'h0000, tx_on}, 16'h0000);
    rdchk(7'h07, 16'h0000);
    // Continuous receive: length byte and auto stop cleared first
    wr(7'h07, 16'h0000);
    wr(7'h29, 16'h0000);
    wr(7'h07, 16'h0080);
    wait_run();
    for (int i = 0; i < 8; i++) begin
      rx_line_bit = PAT[i];
      rx_line_strobe = 1'b1;
      tk();
      rx_line_strobe = 1'b0;
      check({14'h0000, rx_data_strobe, rx_data_bit}, {14'h0000, 1'b1, PAT[i]});
      tk();
    end
    wr(7'h07, 16'h0000);
    check({12'h000, run_state, tx_on, rx_on}, 16'h0000);
    results();
  end
endmodule : radio_control_register_bank_tb

bind radio_control_register_bank radio_bank_checker #(.CAL_CYCLES_P(CAL_CYCLES_P))
  u_radio_bank_checker (.clk(clk), .rst(rst), .spi_ss_n(spi_ss_n),
  .spi_miso_oe(spi_miso_oe), .rx_line_bit(rx_line_bit), .rx_line_strobe(rx_line_strobe),
  .rx_data_bit(rx_data_bit), .rx_data_strobe(rx_data_strobe), .rf_setup(rf_setup),
  .packet_format(packet_format), .run_state(run_state), .osc_cal_active(osc_cal_active),
  .tx_on(tx_on), .rx_on(rx_on), .tx_tone(tx_tone));
